// ---- hdl/nv_access_pkg.sv ----
// Constants for the byte EEPROM access controller.
// Assumes a single CPU clock of 50 MHz and an 8-bit I/O register port.
package nv_access_pkg;
  // Register port indices within the block.
  localparam logic [1:0] ADDR_LOW_IDX  = 2'h0;
  localparam logic [1:0] ADDR_HIGH_IDX = 2'h1;
  localparam logic [1:0] DATA_IDX      = 2'h2;
  localparam logic [1:0] CONTROL_IDX   = 2'h3;
  // Control register field positions.
  localparam int READ_BIT   = 0;
  localparam int STROBE_BIT = 1;
  localparam int ARM_BIT    = 2;
  localparam int IRQ_EN_BIT = 3;
  localparam int MODE_LO    = 4;
  localparam int MODE_HI    = 5;
  // Storage geometry.
  localparam int DEPTH      = 512;
  localparam int ADDR_W     = 9;
  // Programming modes.
  localparam logic [1:0] MODE_ATOMIC   = 2'h0;
  localparam logic [1:0] MODE_ERASE    = 2'h1;
  localparam logic [1:0] MODE_WRITE    = 2'h2;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [7:0] DATA_RESET    = 8'h00;
  // Timing.
  localparam int CLK_HZ        = 50000000;
  localparam int ATOMIC_US     = 3400;
  localparam int SPLIT_US      = 1800;
  localparam int ATOMIC_CYCLES = ATOMIC_US * (CLK_HZ / 1000000);
  localparam int SPLIT_CYCLES  = SPLIT_US * (CLK_HZ / 1000000);
  localparam int ARM_CYCLES    = 4;
  localparam int READ_STALL    = 4;
  localparam int WRITE_STALL   = 2;
  localparam int TIMER_W       = 18;
  localparam int STALL_W       = 3;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_BUSY  = 2'b01
  } prog_state_e;
endpackage : nv_access_pkg

// ---- hdl/nv_byte_store.sv ----
// Byte storage array: 512 bytes, one write port and one read port.
// Assumes the controller presents addresses within range.
`timescale 1ns/10ps
module nv_byte_store #(
  parameter int DEPTH  = 512,
  parameter int ADDR_W = 9
) (
  // Clock.
  input  wire logic              clk_sys,
  // Write port.
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [7:0]        wr_data,
  // Read port.
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [7:0]        rd_data
);
  logic [7:0] mem [DEPTH];

  // Unregistered read so a fetched byte lands in the data register in one cycle.
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule : nv_byte_store

// ---- hdl/nv_access_ctrl.sv ----
// Byte EEPROM access controller: address, data and control registers,
// self-timed programming, CPU stall and level ready interrupt.
// Assumes the CPU core drives the I/O port synchronously on clk_sys.
//
// Behaviour
// - Storage holds 512 bytes addressed linearly from 0 to 511.
// - Address bits 15..9 ignore writes and read as zero.
// - Control bits 7..6 ignore writes and read as zero.
// - Data register supplies write byte and receives the read byte.
// - A read stalls the CPU for four cycles.
// - Starting a write stalls the CPU for two cycles.
// - Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms.
// - Mode field writes are ignored while the write strobe is set.
// - Reset clears mode to 00 unless programming is in progress.
// - Ready interrupt enabled by enable bit together with global enable.
// - Ready interrupt is a level held while write strobe is clear.
// - Ready interrupt suppressed during writes and flash self-programming.
// - Writes are self-timed; software polls the write strobe.
// - Strobe within four cycles of arm starts a write; arm self-clears after four.
// - Hardware clears the write strobe when programming time ends.
// - Read strobe fetches the addressed byte into the data register at once.
// - During a write, reads are refused and the address is held.
`timescale 1ns/10ps
module nv_access_ctrl
  import nv_access_pkg::*;
#(
  parameter int ATOMIC_TICKS = nv_access_pkg::ATOMIC_CYCLES,
  parameter int SPLIT_TICKS  = nv_access_pkg::SPLIT_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // I/O register port.
  input  wire logic [1:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // CPU side.
  input  wire logic       global_irq_enable,
  input  wire logic       flash_self_program,
  output logic            cpu_stall,
  output logic            ready_irq
);
  import nv_access_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0]  nv_byte_address;
    logic [7:0]         nv_data_byte;
    logic [1:0]         prog_mode;
    logic               ready_irq_enable;
    logic               master_write_arm;
    logic               write_strobe;
    logic [STALL_W-1:0] arm_count;
    logic [STALL_W-1:0] stall_count;
    logic [TIMER_W-1:0] prog_timer;
    prog_state_e        state;
    logic [7:0]         rdata;
    logic               stall;
    logic               irq;
    logic               reset_seen;
  } state_s;

  state_s cur_reg;
  state_s cur_next;

  logic [7:0] store_rd;
  logic       store_wr;
  logic [7:0] store_wdata;

  // Byte value written back when programming ends, per mode.
  function automatic logic [7:0] prog_result(input logic [1:0] mode,
                                             input logic [7:0] old_b,
                                             input logic [7:0] new_b);
    case (mode)
      MODE_ATOMIC: prog_result = new_b;
      MODE_ERASE:  prog_result = ERASED_BYTE;
      MODE_WRITE:  prog_result = old_b & new_b;
      default:     prog_result = old_b;
    endcase
  endfunction : prog_result

  nv_byte_store #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_store (
    .clk_sys (clk_sys),
    .wr_en   (store_wr),
    .wr_addr (cur_reg.nv_byte_address),
    .wr_data (store_wdata),
    .rd_addr (cur_reg.nv_byte_address),
    .rd_data (store_rd)
  );

  assign store_wdata = prog_result(cur_reg.prog_mode, store_rd, cur_reg.nv_data_byte);

  // Storage is written at the last programming cycle, not earlier, so an
  // interrupted timer never leaves a half-done byte.
  assign store_wr = (cur_reg.state == ST_BUSY) && (cur_reg.prog_timer == '0)
                    && (cur_reg.prog_mode != MODE_RESERVED);

  // Next-state logic for all registers.
  always_comb begin
    cur_next = cur_reg;
    // First cycle after reset: the mode returns to 00 only when no write runs.
    // An unknown state after power-up falls to the default branch and settles.
    if (cur_reg.reset_seen) begin
      cur_next.reset_seen = 1'b0;
      case (cur_reg.state)
        ST_BUSY: ;
        default: begin
          cur_next.state        = ST_IDLE;
          cur_next.write_strobe = 1'b0;
          cur_next.prog_mode    = MODE_ATOMIC;
        end
      endcase
    end
    // Arm bit times out by itself.
    if (cur_reg.master_write_arm) begin
      if (cur_reg.arm_count == STALL_W'(ARM_CYCLES - 1)) begin
        cur_next.master_write_arm = 1'b0;
        cur_next.arm_count        = '0;
      end else begin
        cur_next.arm_count = cur_reg.arm_count + 1'b1;
      end
    end
    // Stall countdown.
    if (cur_reg.stall_count != '0) begin
      cur_next.stall_count = cur_reg.stall_count - 1'b1;
    end
    // Self-timed programming.
    if (cur_reg.state == ST_BUSY) begin
      if (cur_reg.prog_timer == '0) begin
        cur_next.state        = ST_IDLE;
        cur_next.write_strobe = 1'b0;
      end else begin
        cur_next.prog_timer = cur_reg.prog_timer - 1'b1;
      end
    end
    // Register writes from the CPU.
    if (io_wr) begin
      case (io_addr)
        ADDR_LOW_IDX: begin
          if (cur_reg.state != ST_BUSY) begin
            cur_next.nv_byte_address[7:0] = io_wdata;
          end
        end
        ADDR_HIGH_IDX: begin
          if (cur_reg.state != ST_BUSY) begin
            cur_next.nv_byte_address[ADDR_W-1] = io_wdata[0];
          end
        end
        DATA_IDX: cur_next.nv_data_byte = io_wdata;
        CONTROL_IDX: begin
          if (!cur_reg.write_strobe) begin
            cur_next.prog_mode = io_wdata[MODE_HI:MODE_LO];
          end
          cur_next.ready_irq_enable = io_wdata[IRQ_EN_BIT];
          if (io_wdata[ARM_BIT] && !io_wdata[STROBE_BIT]) begin
            cur_next.master_write_arm = 1'b1;
            cur_next.arm_count        = '0;
          end
          if (io_wdata[STROBE_BIT] && cur_reg.master_write_arm
              && !cur_reg.write_strobe && !flash_self_program) begin
            cur_next.write_strobe = 1'b1;
            cur_next.state        = ST_BUSY;
            cur_next.master_write_arm = 1'b0;
            cur_next.prog_timer   = (cur_next.prog_mode == MODE_ATOMIC)
                                  ? TIMER_W'(ATOMIC_TICKS - 1)
                                  : TIMER_W'(SPLIT_TICKS - 1);
            cur_next.stall_count  = STALL_W'(WRITE_STALL);
          end else if (io_wdata[READ_BIT] && cur_reg.state != ST_BUSY) begin
            cur_next.nv_data_byte = store_rd;
            cur_next.stall_count  = STALL_W'(READ_STALL);
          end
        end
        default: ;
      endcase
    end
    // Read data mux; unused high bits read zero.
    case (io_addr)
      ADDR_LOW_IDX:  cur_next.rdata = cur_next.nv_byte_address[7:0];
      ADDR_HIGH_IDX: cur_next.rdata = {7'h00, cur_next.nv_byte_address[ADDR_W-1]};
      DATA_IDX:      cur_next.rdata = cur_next.nv_data_byte;
      CONTROL_IDX:   cur_next.rdata = {2'h0, cur_next.prog_mode,
                                       cur_next.ready_irq_enable,
                                       cur_next.master_write_arm,
                                       cur_next.write_strobe, 1'b0};
      default:       cur_next.rdata = 8'h00;
    endcase
    cur_next.stall = (cur_next.stall_count != '0);
    // Level request, no latched flag.
    cur_next.irq = cur_next.ready_irq_enable && global_irq_enable
                   && !cur_next.write_strobe
                   && !flash_self_program;
  end

  // Address, mode, strobe, state and timer carry no reset term, so a running
  // write survives reset and the address stays undefined until written.
  // Trade-off: the timer pauses while reset is held, which only stretches
  // that write; the mode is settled in the first cycle after release.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_reg.nv_data_byte     <= DATA_RESET;
      cur_reg.ready_irq_enable <= 1'b0;
      cur_reg.master_write_arm <= 1'b0;
      cur_reg.arm_count        <= '0;
      cur_reg.stall_count      <= '0;
      cur_reg.rdata            <= 8'h00;
      cur_reg.stall            <= 1'b0;
      cur_reg.irq              <= 1'b0;
      cur_reg.reset_seen       <= 1'b1;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign io_rdata  = cur_reg.rdata;
  assign cpu_stall = cur_reg.stall;
  assign ready_irq = cur_reg.irq;
endmodule : nv_access_ctrl

// ---- tb/cpu_port_model.sv ----
// CPU core model driving the controller's I/O register port.
// Assumes callers enter each task just after a rising clk_sys edge.
`timescale 1ns/10ps
module cpu_port_model
  import nv_access_pkg::*;
(
  input  wire logic       clk_sys,
  output logic      [1:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  // The port idles with no strobe raised.
  initial begin
    io_addr = DATA_IDX;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // One write; released data is inverted so a stale byte never looks valid.
  // An idle edge comes first, so two transfers in a row never touch a strobe
  // twice in one time step.
  task automatic put(input logic [1:0] idx, input logic [7:0] val);
    @(posedge clk_sys);
    #1;
    io_addr = idx;
    io_wdata = val;
    io_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    io_wr = 1'b0;
    io_wdata = ~val;
  endtask : put
  // One read; the registered answer is taken one edge later.
  task automatic get(input logic [1:0] idx, output logic [7:0] val);
    @(posedge clk_sys);
    #1;
    io_addr = idx;
    io_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    io_rd = 1'b0;
    val = io_rdata;
  endtask : get
  // Arm, then strobe two cycles later while the arm is still live.
  task automatic start_write(input logic [1:0] mode, input logic en);
    put(CONTROL_IDX, {2'h0, mode, en, 3'h4});
    put(CONTROL_IDX, {2'h0, mode, en, 3'h2});
  endtask : start_write
endmodule : cpu_port_model

// ---- tb/nv_access_props.sv ----
// Port checker for the access controller.
// Assumes it is bound to nv_access_ctrl and clocked by clk_sys.
`timescale 1ns/10ps
module nv_access_props
  import nv_access_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] io_addr,
  input wire logic       io_wr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic       global_irq_enable,
  input wire logic       flash_self_program,
  input wire logic       cpu_stall,
  input wire logic       ready_irq
);
  logic [2:0] arm_age;
  wire        ctl_wr = io_wr && io_addr == CONTROL_IDX;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Cycles since the last arm write; saturates so a stale arm stays stale.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) arm_age <= 3'h7;
    else if (ctl_wr && io_wdata[ARM_BIT]) arm_age <= 3'h0;
    else if (arm_age != 3'h7) arm_age <= arm_age + 3'h1;
  end
  a_irq_needs_global: assert property (ready_irq |-> $past(global_irq_enable))
    else $error("ready irq without global enable");
  a_irq_spm_mute: assert property (ready_irq |-> !$past(flash_self_program))
    else $error("ready irq during flash self programming");
  a_stall_min: assert property ($rose(cpu_stall) |-> cpu_stall[*2])
    else $error("stall shorter than two cycles");
  a_stall_max: assert property ($rose(cpu_stall) |-> ##4 !cpu_stall)
    else $error("stall longer than four cycles");
  a_stall_cause: assert property ($rose(cpu_stall) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("stall without a control write");
  a_ctrl_unused: assert property ($past(io_addr) == CONTROL_IDX |-> io_rdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  a_high_unused: assert property ($past(io_addr) == ADDR_HIGH_IDX |-> io_rdata[7:1] == 7'h0)
    else $error("address high unused bits not zero");
  // An arm written at edge A is live for strobes up to edge A+4, where the age reads 3.
  a_unarmed_strobe: assert property (ctl_wr && io_wdata[STROBE_BIT] && !io_wdata[ARM_BIT] &&
    arm_age >= 3'h4 |-> ##1 (!cpu_stall)[*3])
    else $error("write started without live arm");
  a_arm_lapse: assert property ($past(io_addr) == CONTROL_IDX && arm_age == 3'h7
    |-> !io_rdata[ARM_BIT])
    else $error("arm bit did not expire");
endmodule : nv_access_props

// ---- tb/testbench.sv ----
// Self-checking bench for the access controller.
// Assumes shortened programming times so writes end in tens of cycles.
`timescale 1ns/10ps
module testbench;
  import nv_access_pkg::*;
  localparam int ATOM = 24;
  localparam int SPLT = 10;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       global_irq_enable = 1'b0;
  logic       flash_self_program = 1'b0;
  logic [1:0] io_addr;
  logic       io_wr, io_rd, cpu_stall, ready_irq;
  logic [7:0] io_wdata, io_rdata, rv;
  int         fails = 0;
  int         n_checks = 0;
  int         cyc = 0;
  // Clock and a cycle count used to tell long from short programming.
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  cpu_port_model cpu (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  nv_access_ctrl #(.ATOMIC_TICKS(ATOM), .SPLIT_TICKS(SPLT)) uut (.clk_sys(clk_sys), .rst(rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .flash_self_program(flash_self_program),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  // Count stall cycles over a window longer than any legal stall.
  task automatic stall_len(input logic [7:0] exp);
    int n;
    n = 0;
    repeat (6) begin
      if (cpu_stall === 1'b1) n++;
      @(posedge clk_sys);
      #1;
    end
    chk("stall", exp, 8'(n));
  endtask : stall_len
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("ready irq", {7'h0, v}, {7'h0, ready_irq});
  endtask : irq_is
  // Poll the strobe bit; a hang counts as a mismatch and ends the run.
  task automatic wait_idle();
    int n;
    n = 0;
    rv = 8'h02;
    while (rv[STROBE_BIT] !== 1'b0) begin
      cpu.get(CONTROL_IDX, rv);
      n++;
      if (n > 200) begin
        fails++;
        final_report();
      end
    end
  endtask : wait_idle
  task automatic set_addr(input logic [8:0] a);
    cpu.put(ADDR_LOW_IDX, a[7:0]);
    cpu.put(ADDR_HIGH_IDX, {7'h0, a[8]});
  endtask : set_addr
  task automatic pulse_rst();
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
  endtask : pulse_rst
  // Atomic writes also try to change mode, address and data while busy.
  task automatic do_write(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d);
    int t0;
    set_addr(a);
    cpu.put(DATA_IDX, d);
    cpu.start_write(m, 1'b0);
    t0 = cyc;
    stall_len(8'h02);
    if (m == MODE_ATOMIC) begin
      cpu.put(CONTROL_IDX, 8'h12);
      cpu.put(ADDR_LOW_IDX, ~a[7:0]);
      cpu.put(CONTROL_IDX, 8'h01);
      cpu.get(CONTROL_IDX, rv);
      chk("mode held", 8'h02, rv);
      cpu.get(ADDR_LOW_IDX, rv);
      chk("addr held", a[7:0], rv);
      cpu.get(DATA_IDX, rv);
      chk("data held", d, rv);
    end
    wait_idle();
    if (m != MODE_RESERVED) chk("long", 8'(m == MODE_ATOMIC), 8'((cyc - t0) > 17));
  endtask : do_write
  task automatic do_read(input logic [8:0] a, input logic [7:0] exp);
    set_addr(a);
    cpu.put(CONTROL_IDX, 8'h01);
    stall_len(8'h04);
    cpu.get(DATA_IDX, rv);
    chk("read byte", exp, rv);
  endtask : do_read
  task automatic t_reset_values();
    cpu.get(DATA_IDX, rv);
    chk("data reset", DATA_RESET, rv);
    cpu.put(ADDR_HIGH_IDX, 8'hFF);
    cpu.get(ADDR_HIGH_IDX, rv);
    chk("addr high", 8'h01, rv);
    cpu.put(CONTROL_IDX, 8'hC0);
    cpu.get(CONTROL_IDX, rv);
    chk("control", 8'h00, rv);
  endtask : t_reset_values
  task automatic t_modes();
    do_write(MODE_ATOMIC, 9'h1FF, 8'h5A);
    do_read(9'h1FF, 8'h5A);
    do_write(MODE_WRITE, 9'h1FF, 8'h0F);
    do_read(9'h1FF, 8'h0A);
    do_write(MODE_ERASE, 9'h1FF, 8'h00);
    do_read(9'h1FF, ERASED_BYTE);
    do_write(MODE_ATOMIC, 9'h000, 8'hA5);
    do_write(MODE_RESERVED, 9'h000, 8'h33);
    do_read(9'h000, 8'hA5);
    do_read(9'h1FF, ERASED_BYTE);
  endtask : t_modes
  task automatic t_arm_lapse();
    cpu.put(CONTROL_IDX, 8'h04);
    repeat (6) @(posedge clk_sys);
    #1;
    cpu.put(CONTROL_IDX, 8'h02);
    stall_len(8'h00);
    cpu.get(CONTROL_IDX, rv);
    chk("no write", 8'h00, rv);
  endtask : t_arm_lapse
  task automatic t_irq();
    global_irq_enable = 1'b1;
    cpu.put(CONTROL_IDX, 8'h08);
    irq_is(1'b1);
    flash_self_program = 1'b1;
    irq_is(1'b0);
    flash_self_program = 1'b0;
    global_irq_enable = 1'b0;
    irq_is(1'b0);
    global_irq_enable = 1'b1;
    set_addr(9'h100);
    cpu.start_write(MODE_ERASE, 1'b1);
    irq_is(1'b0);
    wait_idle();
    irq_is(1'b1);
    cpu.put(CONTROL_IDX, 8'h00);
    irq_is(1'b0);
  endtask : t_irq
  task automatic t_reset_busy();
    set_addr(9'h100);
    cpu.start_write(MODE_WRITE, 1'b0);
    pulse_rst();
    cpu.get(CONTROL_IDX, rv);
    chk("mode kept", 8'h22, rv);
    wait_idle();
    pulse_rst();
    cpu.get(CONTROL_IDX, rv);
    chk("mode cleared", 8'h00, rv);
  endtask : t_reset_busy
  // Main sequence: reset for two cycles, then each scenario in turn.
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset_values();
    t_modes();
    t_arm_lapse();
    t_irq();
    t_reset_busy();
    final_report();
  end
endmodule : testbench
bind nv_access_ctrl nv_access_props chk_i (.clk_sys(clk_sys), .rst(rst), .io_addr(io_addr),
  .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .global_irq_enable(global_irq_enable), .flash_self_program(flash_self_program),
  .cpu_stall(cpu_stall), .ready_irq(ready_irq));
